// ### core/gpio_pkg.sv
// shared constants, register map and carrier types for the change-detect port
`default_nettype none
package gpio_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int PORT_W = 6; // six port pins
  localparam int INPUT_ONLY_BIT = 3; // pin 3 has no driver
  localparam int REG_COUNT = 8; // words in the register file
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [11:0] OFF_PIN_LEVELS = 12'h000; // port_pin_levels
  localparam logic [11:0] OFF_DIRECTION = 12'h004; // port_direction
  localparam logic [11:0] OFF_LATCH = 12'h008; // port_output_latch
  localparam logic [11:0] OFF_ANALOG = 12'h00c; // port_analog_select
  localparam logic [11:0] OFF_RISE_EN = 12'h010; // rising_detect_enable
  localparam logic [11:0] OFF_FALL_EN = 12'h014; // falling_detect_enable
  localparam logic [11:0] OFF_FLAGS = 12'h018; // change_flags
  localparam logic [11:0] OFF_CONTROL = 12'h01c; // master enable, summary, pin select
  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTL_MASTER_EN = 0; // change_irq_master_enable
  localparam int CTL_SUMMARY = 1; // change_irq_summary, read only
  localparam int CTL_SEL_WAVE_A = 2; // wavegen a at alternate pin
  localparam int CTL_SEL_WAVE_B = 3; // wavegen b at alternate pin
  localparam int CTL_SEL_LOGIC1 = 4; // logic cell 1 at alternate pin
  localparam int CTL_SEL_NCO = 5; // numeric oscillator at alternate pin
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] RST_DIRECTION = 6'h3f; // all inputs
  localparam logic [5:0] RST_LATCH = 6'h00;
  localparam logic [5:0] RST_ANALOG = 6'h17; // analog pins 0,1,2,4
  localparam logic [5:0] RST_ZERO6 = 6'h00;
  localparam logic [5:0] INPUT_ONLY_MASK = 6'h08; // direction forced high
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // ****************************************
  // carriers
  // ****************************************
  // peripheral output sources, each value with its enable
  typedef struct packed {
    logic prog_data_en, prog_data;
    logic dac1_en, dac2_en; // analog outputs drive level of enable only
    logic wave_a_en, wave_a;
    logic wave_b_en, wave_b;
    logic logic1_en, logic1;
    logic logic2_en, logic2;
    logic cmp1_en, cmp1;
    logic nco_en, nco;
    logic clock_output_pin_en, clock_output_pin;
    logic [3:0] pwm_en;
    logic [3:0] pwm;
  } periph_src_t;
  // pin drive bundle
  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe;
  } pin_drive_t;
endpackage
`default_nettype wire

// ### core/gpio_regfile.sv
// small register memory: registered read data, one write port
`timescale 1ns/1ns
`default_nettype none
module gpio_regfile
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic we_in,
  input wire logic [2:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [2:0] raddr_in,
  output logic [31:0] rdata_out
);
  // scratch word store, cleared at reset
  logic [31:0] mem_reg [0:gpio_pkg::REG_COUNT-1];
  // ****************************************
  // storage and registered read
  // ****************************************
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= gpio_pkg::RD_ZERO;
      for (int i = 0; i < gpio_pkg::REG_COUNT; i++)
        mem_reg[i] <= gpio_pkg::RD_ZERO;
    end
    else
    begin
      if (we_in)
        mem_reg[waddr_in] <= wdata_in;
      rdata_out <= mem_reg[raddr_in];
    end
  end
endmodule
`default_nettype wire

// ### core/port_with_change_interrupt.sv
// six-pin port with output priority mux and change detection, apb slave
`timescale 1ns/1ns
`default_nettype none
module port_with_change_interrupt
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out,
  input wire gpio_pkg::periph_src_t periph_in,
  input wire logic sleep_in,
  output logic change_irq_out,
  output logic wake_out
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_DONE} bus_state_t;
  typedef struct packed {
    bus_state_t bus; // apb answer sequencing
    logic [5:0] sync1; // first synchroniser stage
    logic [5:0] sync2; // second stage
    logic [5:0] prev; // previous synchronised sample
    logic [5:0] dir; // port_direction
    logic [5:0] latch; // port_output_latch
    logic [5:0] analog; // port_analog_select
    logic [5:0] rise_en; // rising_detect_enable
    logic [5:0] fall_en; // falling_detect_enable
    logic [5:0] flags; // change_flags
    logic [5:0] ctl; // master enable and pin selects
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [5:0] pin_lvl;
    logic [5:0] pin_oe;
    logic irq;
    logic wake;
  } state_t;
  state_t state_reg;
  state_t state_next;
  // helper wires
  logic [5:0] dig_in; // digital read view of the pins
  logic [5:0] edges; // enabled edges this cycle
  logic [5:0] src_en; // some peripheral owns the pin
  logic [5:0] src_val; // that peripheral's level
  logic setup; // apb setup phase seen
  logic wr_now; // access phase write
  logic [31:0] mem_rdata; // scratch word from memory
  logic mem_we; // tied low: the scratch store is never written
  logic is_spare; // address lies in no mapped register
  gpio_pkg::periph_src_t p;
  assign p = periph_in;
  // ****************************************
  // input view and edge detection
  // ****************************************
  // analog pins read zero; the sample already passed two flops
  assign dig_in = state_reg.sync2 & ~state_reg.analog;
  // compare consecutive synchronised samples per enable
  assign edges = (state_reg.sync2 & ~state_reg.prev & state_reg.rise_en)
    | (~state_reg.sync2 & state_reg.prev & state_reg.fall_en);
  // ****************************************
  // output priority mux, fixed order
  // ****************************************
  // dac outputs win the pin (dac1 only below prog_data on pin 0) and drive its level low
  always_comb
  begin
    src_en = 6'h00;
    src_val = 6'h00;
    // pin 0
    if (p.prog_data_en)
    begin
      src_en[0] = 1'b1;
      src_val[0] = p.prog_data;
    end
    else if (p.dac1_en)
      src_en[0] = 1'b1;
    else if (p.wave_b_en && !state_reg.ctl[gpio_pkg::CTL_SEL_WAVE_B])
    begin
      src_en[0] = 1'b1;
      src_val[0] = p.wave_b;
    end
    else if (p.pwm_en[1])
    begin
      src_en[0] = 1'b1;
      src_val[0] = p.pwm[1];
    end
    // pin 1
    if (p.nco_en && !state_reg.ctl[gpio_pkg::CTL_SEL_NCO])
    begin
      src_en[1] = 1'b1;
      src_val[1] = p.nco;
    end
    // pin 2
    if (p.dac2_en)
      src_en[2] = 1'b1;
    else if (p.wave_a_en && !state_reg.ctl[gpio_pkg::CTL_SEL_WAVE_A])
    begin
      src_en[2] = 1'b1;
      src_val[2] = p.wave_a;
    end
    else if (p.logic1_en && !state_reg.ctl[gpio_pkg::CTL_SEL_LOGIC1])
    begin
      src_en[2] = 1'b1;
      src_val[2] = p.logic1;
    end
    else if (p.cmp1_en)
    begin
      src_en[2] = 1'b1;
      src_val[2] = p.cmp1;
    end
    else if (p.pwm_en[0])
    begin
      src_en[2] = 1'b1;
      src_val[2] = p.pwm[0];
    end
    // pin 4
    if (p.clock_output_pin_en)
    begin
      src_en[4] = 1'b1;
      src_val[4] = p.clock_output_pin;
    end
    else if (p.wave_b_en && state_reg.ctl[gpio_pkg::CTL_SEL_WAVE_B])
    begin
      src_en[4] = 1'b1;
      src_val[4] = p.wave_b;
    end
    else if (p.logic1_en && state_reg.ctl[gpio_pkg::CTL_SEL_LOGIC1])
    begin
      src_en[4] = 1'b1;
      src_val[4] = p.logic1;
    end
    else if (p.pwm_en[2])
    begin
      src_en[4] = 1'b1;
      src_val[4] = p.pwm[2];
    end
    // pin 5
    if (p.wave_a_en && state_reg.ctl[gpio_pkg::CTL_SEL_WAVE_A])
    begin
      src_en[5] = 1'b1;
      src_val[5] = p.wave_a;
    end
    else if (p.logic2_en)
    begin
      src_en[5] = 1'b1;
      src_val[5] = p.logic2;
    end
    else if (p.nco_en && state_reg.ctl[gpio_pkg::CTL_SEL_NCO])
    begin
      src_en[5] = 1'b1;
      src_val[5] = p.nco;
    end
    else if (p.pwm_en[3])
    begin
      src_en[5] = 1'b1;
      src_val[5] = p.pwm[3];
    end
  end
  // ****************************************
  // bus decode
  // ****************************************
  assign setup = psel_in && !penable_in;
  assign wr_now = psel_in && penable_in && pwrite_in && state_reg.ready;
  assign is_spare = (paddr_in[11:5] != 7'h00) || (paddr_in[1:0] != 2'b00);
  assign mem_we = 1'b0; // map is dense: scratch store stays read-only zero
  gpio_regfile u_regs
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .we_in(mem_we),
    .waddr_in(paddr_in[4:2]),
    .wdata_in(pwdata_in),
    .raddr_in(paddr_in[4:2]),
    .rdata_out(mem_rdata)
  );
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    state_next.ready = 1'b0;
    state_next.slverr = 1'b0;
    // apb: setup, one wait cycle, then ready for one cycle
    case (state_reg.bus)
      BUS_IDLE:
        if (setup)
          state_next.bus = BUS_READ;
      BUS_READ:
      begin
        state_next.bus = BUS_DONE;
        state_next.ready = 1'b1;
        state_next.slverr = is_spare;
        state_next.rdata = gpio_pkg::RD_ZERO;
        case (paddr_in)
          gpio_pkg::OFF_PIN_LEVELS: state_next.rdata[5:0] = dig_in;
          gpio_pkg::OFF_DIRECTION:
            state_next.rdata[5:0] = state_reg.dir | gpio_pkg::INPUT_ONLY_MASK;
          gpio_pkg::OFF_LATCH: state_next.rdata[5:0] = state_reg.latch;
          gpio_pkg::OFF_ANALOG: state_next.rdata[5:0] = state_reg.analog;
          gpio_pkg::OFF_RISE_EN: state_next.rdata[5:0] = state_reg.rise_en;
          gpio_pkg::OFF_FALL_EN: state_next.rdata[5:0] = state_reg.fall_en;
          gpio_pkg::OFF_FLAGS: state_next.rdata[5:0] = state_reg.flags;
          gpio_pkg::OFF_CONTROL:
          begin
            state_next.rdata[5:0] = state_reg.ctl;
            state_next.rdata[gpio_pkg::CTL_SUMMARY] = |state_reg.flags;
          end
          default: state_next.rdata = mem_rdata;
        endcase
        if (pwrite_in)
          state_next.rdata = gpio_pkg::RD_ZERO;
      end
      BUS_DONE:
        state_next.bus = BUS_IDLE;
      default:
        state_next.bus = BUS_IDLE;
    endcase
    // register writes take effect at the ready edge
    if (wr_now && pstrb_in[0])
    begin
      case (paddr_in)
        // port write: written data goes straight to the latch
        gpio_pkg::OFF_PIN_LEVELS: state_next.latch = pwdata_in[5:0];
        gpio_pkg::OFF_DIRECTION: state_next.dir = pwdata_in[5:0];
        gpio_pkg::OFF_LATCH: state_next.latch = pwdata_in[5:0];
        gpio_pkg::OFF_ANALOG: state_next.analog = pwdata_in[5:0];
        gpio_pkg::OFF_RISE_EN: state_next.rise_en = pwdata_in[5:0];
        gpio_pkg::OFF_FALL_EN: state_next.fall_en = pwdata_in[5:0];
        gpio_pkg::OFF_FLAGS: state_next.flags = state_reg.flags & pwdata_in[5:0];
        gpio_pkg::OFF_CONTROL:
        begin
          state_next.ctl = pwdata_in[5:0];
          state_next.ctl[gpio_pkg::CTL_SUMMARY] = 1'b0;
        end
        default: state_next.ctl = state_reg.ctl;
      endcase
    end
    // new edges win over any clear in the same cycle; also counted in sleep
    state_next.flags = state_next.flags | edges;
    // driver: direction and the pin 3 input-only mask gate, analog select ignored
    state_next.pin_oe = ~(state_reg.dir | gpio_pkg::INPUT_ONLY_MASK);
    // peripheral drives ahead of the latch, analog or not
    state_next.pin_lvl = (src_en & src_val) | (~src_en & state_reg.latch);
    state_next.irq = state_reg.ctl[gpio_pkg::CTL_MASTER_EN] && (|state_reg.flags);
    state_next.wake = state_next.irq && sleep_in;
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= '0;
      state_reg.bus <= BUS_IDLE;
      state_reg.dir <= gpio_pkg::RST_DIRECTION;
      state_reg.latch <= gpio_pkg::RST_LATCH;
      state_reg.analog <= gpio_pkg::RST_ANALOG;
      state_reg.flags <= gpio_pkg::RST_ZERO6;
    end
    else
      state_reg <= state_next;
  end
  assign prdata_out = state_reg.rdata;
  assign pready_out = state_reg.ready;
  assign pslverr_out = state_reg.slverr;
  assign pin_out = state_reg.pin_lvl;
  assign pin_oe_out = state_reg.pin_oe;
  assign change_irq_out = state_reg.irq;
  assign wake_out = state_reg.wake;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  chk_pin3_no_drive: assert property (!pin_oe_out[3]) else $error("pin 3 driven");
  chk_irq_needs_master: assert property (
    change_irq_out |-> $past(state_reg.ctl[gpio_pkg::CTL_MASTER_EN]))
    else $error("irq without master enable");
  chk_irq_master_off: assert property (
    !state_reg.ctl[gpio_pkg::CTL_MASTER_EN] |=> !change_irq_out)
    else $error("irq with master disabled");
  chk_flag_on_edge: assert property (
    |edges |=> ((state_reg.flags & $past(edges)) == $past(edges)))
    else $error("edge lost");
  chk_oe_follows_dir: assert property (
    ##1 pin_oe_out == ~($past(state_reg.dir) | gpio_pkg::INPUT_ONLY_MASK))
    else $error("driver not from direction");
  // apb answer in two steps: setup taken while idle, ready after one wait state
  sequence apb_setup_s;
    setup && state_reg.bus == BUS_IDLE;
  endsequence
  sequence apb_answer_s;
    ##1 pready_out;
  endsequence
  chk_ready_timing: assert property (apb_setup_s |=> apb_answer_s)
    else $error("late answer");
  chk_summary_irq: assert property (
    state_reg.ctl[gpio_pkg::CTL_MASTER_EN] && |state_reg.flags |=> change_irq_out)
    else $error("irq missing");
  chk_sync_delay: assert property (state_reg.prev == $past(state_reg.sync2))
    else $error("sample chain broken");
  // wake only ever follows a cycle spent asleep
  chk_wake_needs_sleep: assert property (wake_out |-> $past(sleep_in))
    else $error("wake while awake");
  chk_analog_reads_zero: assert property ((dig_in & state_reg.analog) == 6'h00)
    else $error("analog pin read high");
endmodule
`default_nettype wire

// ### test/ext_pins.sv
// partner model: outside drivers on the six pins, resolved with the port
`timescale 1ns/1ns
`default_nettype none
module ext_pins
(
  input wire logic [5:0] drv_level_in,
  input wire logic [5:0] drv_oe_in,
  input wire logic [5:0] ext_level_in,
  output logic [5:0] pin_level_out
);
  // ****************************************
  // wire resolution
  // ****************************************
  // a pin the port drives shows its level, else the outside level; the outside
  // always drives, so a released pin never keeps a stale value
  always_comb
  begin
    pin_level_out = (drv_level_in & drv_oe_in) | (ext_level_in & ~drv_oe_in);
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the change-detect port over apb
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic mclk_in, sys_rst_in, psel, penable, pwrite, sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, irq, wake, err;
  logic [5:0] pin_in, pin_out, pin_oe, ext;
  gpio_pkg::periph_src_t periph;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ****************************************
  // clock, design and partner
  // ****************************************
  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  port_with_change_interrupt dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe), .periph_in(periph),
    .sleep_in(sleep), .change_irq_out(irq), .wake_out(wake));
  ext_pins u_pins (.drv_level_in(pin_out), .drv_oe_in(pin_oe), .ext_level_in(ext),
    .pin_level_out(pin_in));
  // ****************************************
  // tasks
  // ****************************************
  // verdict, reached from the main sequence or a timeout
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one compare for every value kind, widened to a word
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a wait that runs out counts as a mismatch and ends the run
    if (n >= 20)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb_xfer(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
    chk("pslverr", 32'h0000_0000, {31'h0000_0000, err});
  endtask
  // settle through registered outputs, then look at one pin
  task automatic pin_chk(input int b, input logic e);
    repeat (3) @(posedge mclk_in);
    chk("pin_out", {31'h0000_0000, e}, {31'h0000_0000, pin_out[b]});
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_rst_in = 1'b1;
    {psel, penable, pwrite, sleep} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    ext = 6'h08;
    periph = '0;
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    // reset values
    rd_chk(gpio_pkg::OFF_DIRECTION, 32'h0000_003f);
    rd_chk(gpio_pkg::OFF_ANALOG, 32'h0000_0017);
    chk("pin_oe", 32'h0000_0000, {26'h000_0000, pin_oe});
    // drivers on, pin 3 stays input, analog pins still drive
    apb_xfer(1'b1, gpio_pkg::OFF_DIRECTION, 32'h0000_0000);
    rd_chk(gpio_pkg::OFF_DIRECTION, 32'h0000_0008);
    apb_xfer(1'b1, gpio_pkg::OFF_PIN_LEVELS, 32'h0000_002a);
    repeat (4) @(posedge mclk_in);
    chk("pin_oe", 32'h0000_0037, {26'h000_0000, pin_oe});
    chk("pin_out", 32'h0000_0022, {26'h000_0000, pin_out & pin_oe});
    rd_chk(gpio_pkg::OFF_LATCH, 32'h0000_002a);
    rd_chk(gpio_pkg::OFF_PIN_LEVELS, 32'h0000_0028);
    apb_xfer(1'b1, gpio_pkg::OFF_ANALOG, 32'h0000_0000);
    repeat (4) @(posedge mclk_in);
    rd_chk(gpio_pkg::OFF_PIN_LEVELS, 32'h0000_002a);
    // refused place
    apb_xfer(1'b1, 12'h020, 32'h0000_00ff);
    chk("unmapped_wr", 32'h0000_0001, {rd[30:0], err});
    apb_xfer(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    apb_xfer(1'b0, 12'h006, 32'h0000_0000);
    chk("unaligned", 32'h0000_0001, {rd[30:0], err});
    // lane 0 strobe off: the write is dropped, latch keeps its value
    pstrb <= 4'h0;
    apb_xfer(1'b1, gpio_pkg::OFF_LATCH, 32'h0000_0000);
    pstrb <= 4'hf;
    rd_chk(gpio_pkg::OFF_LATCH, 32'h0000_002a);
    // output priority, each step enables a source above the last
    apb_xfer(1'b1, gpio_pkg::OFF_LATCH, 32'h0000_003f);
    apb_xfer(1'b1, gpio_pkg::OFF_ANALOG, 32'h0000_0017);
    periph.pwm_en[1] <= 1'b1;
    pin_chk(0, 1'b0);
    periph.wave_b_en <= 1'b1;
    periph.wave_b <= 1'b1;
    pin_chk(0, 1'b1);
    periph.dac1_en <= 1'b1;
    pin_chk(0, 1'b0);
    periph.prog_data_en <= 1'b1;
    periph.prog_data <= 1'b1;
    periph.nco_en <= 1'b1;
    periph.pwm_en[0] <= 1'b1;
    pin_chk(0, 1'b1);
    pin_chk(1, 1'b0);
    pin_chk(2, 1'b0);
    periph.cmp1_en <= 1'b1;
    periph.cmp1 <= 1'b1;
    pin_chk(2, 1'b1);
    periph.logic1_en <= 1'b1;
    pin_chk(2, 1'b0);
    periph.wave_a_en <= 1'b1;
    periph.wave_a <= 1'b1;
    pin_chk(2, 1'b1);
    periph.dac2_en <= 1'b1;
    pin_chk(2, 1'b0);
    // alternate locations for wavegen a and b, logic cell 1, oscillator
    apb_xfer(1'b1, gpio_pkg::OFF_CONTROL, 32'h0000_003c);
    pin_chk(1, 1'b1);
    pin_chk(4, 1'b1);
    periph.clock_output_pin_en <= 1'b1;
    pin_chk(4, 1'b0);
    pin_chk(5, 1'b1);
    periph.wave_a_en <= 1'b0;
    pin_chk(5, 1'b0);
    periph.logic2_en <= 1'b1;
    periph.logic2 <= 1'b1;
    pin_chk(5, 1'b1);
    // lowest source on pin 5 drives low against a high latch
    periph.logic2_en <= 1'b0;
    periph.nco_en <= 1'b0;
    periph.pwm_en[3] <= 1'b1;
    pin_chk(5, 1'b0);
    // change detection: pins become inputs, outside drives them
    periph <= '0;
    ext <= 6'h00;
    apb_xfer(1'b1, gpio_pkg::OFF_DIRECTION, 32'h0000_003f);
    apb_xfer(1'b1, gpio_pkg::OFF_ANALOG, 32'h0000_0000);
    apb_xfer(1'b1, gpio_pkg::OFF_CONTROL, 32'h0000_0000);
    apb_xfer(1'b1, gpio_pkg::OFF_RISE_EN, 32'h0000_0001);
    apb_xfer(1'b1, gpio_pkg::OFF_FALL_EN, 32'h0000_0002);
    apb_xfer(1'b1, gpio_pkg::OFF_FLAGS, 32'h0000_0000);
    ext <= 6'h03;
    repeat (5) @(posedge mclk_in);
    rd_chk(gpio_pkg::OFF_FLAGS, 32'h0000_0001);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    ext <= 6'h01;
    repeat (5) @(posedge mclk_in);
    rd_chk(gpio_pkg::OFF_FLAGS, 32'h0000_0003);
    rd_chk(gpio_pkg::OFF_CONTROL, 32'h0000_0002);
    apb_xfer(1'b1, gpio_pkg::OFF_CONTROL, 32'h0000_0001);
    repeat (3) @(posedge mclk_in);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    sleep <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk("wake", 32'h0000_0001, {31'h0000_0000, wake});
    // and-mask clear keeps bit 1
    apb_xfer(1'b1, gpio_pkg::OFF_FLAGS, 32'h0000_0002);
    rd_chk(gpio_pkg::OFF_FLAGS, 32'h0000_0002);
    ext <= 6'h00;
    repeat (5) @(posedge mclk_in);
    // a rising edge lands on the clearing write's own edge
    fork
      apb_xfer(1'b1, gpio_pkg::OFF_FLAGS, 32'h0000_0000);
      begin
        @(posedge mclk_in);
        ext <= 6'h01;
      end
    join
    repeat (3) @(posedge mclk_in);
    rd_chk(gpio_pkg::OFF_FLAGS, 32'h0000_0001);
    apb_xfer(1'b1, gpio_pkg::OFF_FLAGS, 32'h0000_0000);
    repeat (3) @(posedge mclk_in);
    rd_chk(gpio_pkg::OFF_CONTROL, 32'h0000_0001);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    chk("wake", 32'h0000_0000, {31'h0000_0000, wake});
    stop_test();
  end
endmodule
`default_nettype wire
